// File: rtl/stm_map.svh
// Register offsets, field positions and reset values of the standard timer
`ifndef STM_MAP_SVH
`define STM_MAP_SVH
`define STM_OFF_CTRL0 12'h000
`define STM_OFF_CTRL1 12'h004
`define STM_OFF_CNTL 12'h008
`define STM_OFF_CNTH 12'h00C
`define STM_OFF_CMPAL 12'h010
`define STM_OFF_CMPAH 12'h014
`define STM_OFF_CMPP 12'h018
`define STM_OFF_FLAGS 12'h01C
`define STM_C0_ON 3
`define STM_C0_PAUSE 7
`define STM_C1_CCLR 0
`define STM_C1_DPX 1
`define STM_C1_POL 2
`define STM_C1_OC 3
`define STM_FLAG_A 0
`define STM_FLAG_P 1
`define STM_RST_BYTE 8'h00
`define STM_PRESCALE_DEF 16'h0001
`endif

// File: rtl/stm_pkg.sv
// Types of the standard timer
package stm_pkg;
  typedef enum logic [1:0] {
    STM_MODE_CMP = 2'h0,
    STM_MODE_CAP = 2'h1,
    STM_MODE_PWM = 2'h2,
    STM_MODE_TMR = 2'h3
  } stm_mode_t;
  typedef struct packed {
    logic [1:0] modeSelect;
    logic [1:0] outputActionSelect;
    logic outputInitialLevel;
    logic outputInvert;
    logic pwmRoleSwap;
    logic clearSourceSelect;
  } stm_ctrl1_t;
  typedef enum {STM_IDLE, STM_RUN} stm_state_t;
endpackage

// File: rtl/stm_timer.sv
// Standard 16-bit timer: compare match, timer/counter and PWM, APB slave
//
// Contract
// - output_invert inverts pin in every mode
// - pwm_role_swap swaps period and duty registers
// - clear_source_select picks A match or P/overflow
// - Overflow clear only when compare_p_value zero
// - clear_source_select ignored outside compare/timer modes
// - P compares with counter bits 15..8
// - Mode 00 is compare match output
// - Clear source zero raises both flags
// - Clear source one raises only A flag
// - Only comparator A changes pin
// - A match sets, clears or toggles pin
// - counter_on rise loads initial pin level
// - Mode 11 like compare, pin unused
// - Mode 10 is PWM, one period one duty
// - PWM raises both match flags
// - PWM polarity, enable/force and invert controls
// - Duty at or above period gives 100%
// - Swapped: duty from P times 256
// - PWM counting continues when pin forced
// - Period clear starts a new PWM period
// - PWM action codes force, force, wave, force
// - counter_on rise clears, fall holds counter
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stm_map.svh"
module stm_timer #(
  parameter logic [15:0] PRESCALE = `STM_PRESCALE_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timerOutputPin,
  output logic timerOutputEnable,
  output logic matchAPulse,
  output logic matchPPulse
);
  logic [7:0] ctrl0_q;
  stm_pkg::stm_ctrl1_t ctrl1_q;
  logic [15:0] cmpA_q;
  logic [7:0] compareP_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] pre_q;
  logic onPrev_q;
  logic flagA_q;
  logic flagP_q;
  logic pinCmp_q;
  logic pinCmp_d;

  // APB decode; single wait-free access phase
  wire logic apbAccess = psel && penable;
  wire logic apbWr = apbAccess && pwrite;
  wire logic hitCtrl0 = (paddr == `STM_OFF_CTRL0);
  wire logic hitCtrl1 = (paddr == `STM_OFF_CTRL1);
  wire logic hitCntL = (paddr == `STM_OFF_CNTL);
  wire logic hitCntH = (paddr == `STM_OFF_CNTH);
  wire logic hitAL = (paddr == `STM_OFF_CMPAL);
  wire logic hitAH = (paddr == `STM_OFF_CMPAH);
  wire logic hitP = (paddr == `STM_OFF_CMPP);
  wire logic hitFlags = (paddr == `STM_OFF_FLAGS);
  wire logic hitAny = hitCtrl0 | hitCtrl1 | hitCntL | hitCntH | hitAL |
                      hitAH | hitP | hitFlags;
  wire logic [7:0] rdByte =
    hitCtrl0 ? ctrl0_q :
    hitCtrl1 ? ctrl1_q :
    hitCntL ? count_q[7:0] :
    hitCntH ? count_q[15:8] :
    hitAL ? cmpA_q[7:0] :
    hitAH ? cmpA_q[15:8] :
    hitP ? compareP_q :
    hitFlags ? {6'h00, flagP_q, flagA_q} : 8'h00;

  // Mode decode
  wire stm_pkg::stm_mode_t mode = stm_pkg::stm_mode_t'(ctrl1_q.modeSelect);
  wire logic modeCmp = (mode == stm_pkg::STM_MODE_CMP);
  wire logic modeTmr = (mode == stm_pkg::STM_MODE_TMR);
  wire logic modePwm = (mode == stm_pkg::STM_MODE_PWM);
  wire logic counterOn = ctrl0_q[`STM_C0_ON];
  wire logic paused = ctrl0_q[`STM_C0_PAUSE];
  wire logic onRise = counterOn && !onPrev_q;

  // Timer clock enable from the system clock divider
  wire logic tick = (pre_q == PRESCALE - 16'h0001);
  wire logic run = counterOn && !paused && tick && !onRise;

  // Comparators: P matches on the upper byte while the lower byte is zero
  wire logic matchA = run && (count_q + 16'h0001 == cmpA_q);
  wire logic [15:0] nextCnt = count_q + 16'h0001;
  wire logic pZero = (compareP_q == 8'h00);
  // P match on reaching value*256, or on wrap when zero
  wire logic matchP = run && (pZero ? (count_q == 16'hFFFF) :
                      (nextCnt[15:8] == compareP_q &&
                       nextCnt[7:0] == 8'h00));
  wire logic overflow = run && (count_q == 16'hFFFF);

  // Clear selection; clear source only counts in compare/timer modes
  wire logic cmpLike = modeCmp || modeTmr;
  wire logic clrSel = ctrl1_q.clearSourceSelect;
  wire logic clrCmp = clrSel ? matchA :
                      (matchP || (pZero && overflow));
  wire logic periodMatch = ctrl1_q.pwmRoleSwap ? matchA : matchP;
  wire logic clrNow = cmpLike ? clrCmp :
                      modePwm ? periodMatch : overflow;
  wire logic setA = matchA;
  wire logic setP = matchP && !(cmpLike && clrSel);

  // PWM duty compare: active from period start until duty reached
  wire logic [16:0] dutyVal = ctrl1_q.pwmRoleSwap ?
    (pZero ? 17'h10000 : {1'b0, compareP_q, 8'h00}) :
    {1'b0, cmpA_q};
  wire logic [16:0] periodVal = ctrl1_q.pwmRoleSwap ? {1'b0, cmpA_q} :
    (pZero ? 17'h10000 : {1'b0, compareP_q, 8'h00});
  wire logic dutyFull = (dutyVal >= periodVal);
  wire logic pwmActive = dutyFull || ({1'b0, count_q} < dutyVal);
  wire logic ocLevel = ctrl1_q.outputInitialLevel;
  wire logic [1:0] ioSel = ctrl1_q.outputActionSelect;
  // Code 11 drives inactive, the same as code 00
  wire logic pwmLogical = (ioSel == 2'h1) ? 1'b1 :
                          (ioSel == 2'h2) ? pwmActive : 1'b0;
  wire logic pwmLevel = ocLevel ? pwmLogical : !pwmLogical;
  wire logic pinRaw = modePwm ? pwmLevel : pinCmp_q;
  wire logic pinOut = pinRaw ^ ctrl1_q.outputInvert;

  always_comb begin
    pinCmp_d = pinCmp_q;
    if (onRise && modeCmp) begin
      pinCmp_d = ocLevel;
    end else if (modeCmp && matchA) begin
      case (ioSel)
        2'h1: pinCmp_d = 1'b0;
        2'h2: pinCmp_d = 1'b1;
        2'h3: pinCmp_d = !pinCmp_q;
        default: pinCmp_d = pinCmp_q;
      endcase
    end
  end

  always_comb begin
    count_d = count_q;
    if (onRise) begin
      count_d = 16'h0000;
    end else if (clrNow) begin
      count_d = 16'h0000;
    end else if (run) begin
      count_d = nextCnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_q <= 16'h0000;
    end else if (tick) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= 16'h0000;
      onPrev_q <= 1'b0;
      pinCmp_q <= 1'b0;
    end else begin
      count_q <= count_d;
      onPrev_q <= counterOn;
      pinCmp_q <= pinCmp_d;
    end
  end

  // Flag set wins over a same-cycle write-one-to-clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flagA_q <= 1'b0;
      flagP_q <= 1'b0;
    end else begin
      flagA_q <= setA ||
        (flagA_q && !(apbWr && hitFlags && pwdata[`STM_FLAG_A]));
      flagP_q <= setP ||
        (flagP_q && !(apbWr && hitFlags && pwdata[`STM_FLAG_P]));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl0_q <= `STM_RST_BYTE;
      ctrl1_q <= `STM_RST_BYTE;
      cmpA_q <= {`STM_RST_BYTE, `STM_RST_BYTE};
      compareP_q <= `STM_RST_BYTE;
    end else if (apbWr) begin
      if (hitCtrl0) ctrl0_q <= {pwdata[7:3], 3'h0};
      if (hitCtrl1) ctrl1_q <= pwdata[7:0];
      if (hitAL) cmpA_q[7:0] <= pwdata[7:0];
      if (hitAH) cmpA_q[15:8] <= pwdata[7:0];
      if (hitP) compareP_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      timerOutputPin <= 1'b0;
      timerOutputEnable <= 1'b1;
      matchAPulse <= 1'b0;
      matchPPulse <= 1'b0;
    end else begin
      prdata <= {24'h000000, rdByte};
      pready <= 1'b1;
      // Taken in setup so it stands at the access edge
      pslverr <= psel && !hitAny;
      timerOutputPin <= pinOut;
      // Enable low while driving; pin released in timer/counter mode
      timerOutputEnable <= !(modeCmp || modePwm);
      matchAPulse <= setA;
      matchPPulse <= setP;
    end
  end
endmodule // stm_timer
`default_nettype wire

// File: dv/stm_load_model.sv
// Load hanging on the timer output pin
`timescale 1ns/1ps
`default_nettype none
module stm_load_model (
  input wire logic timerOutputPin,
  input wire logic timerOutputEnable,
  output logic loadLevel
);
  // Pull-up holds the line high once the pin is released
  assign loadLevel = timerOutputEnable ? 1'b1 : timerOutputPin;
endmodule // stm_load_model
`default_nettype wire

// File: dv/stm_timer_checker.sv
// Port assertions of the standard timer
`timescale 1ns/1ps
`default_nettype none
`include "stm_map.svh"
module stm_timer_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timerOutputPin,
  input wire logic timerOutputEnable,
  input wire logic matchAPulse,
  input wire logic matchPPulse
);
  stm_pkg::stm_ctrl1_t c1Q;
  logic [1:0] quietQ;
  wire logic wrEn = psel && penable && pwrite;
  // Settled: three edges with no write, so config effects have landed
  wire logic quiet = quietQ == 2'h3;
  always_ff @(posedge ref_clk) begin
    if (rst) c1Q <= '0;
    else if (wrEn && paddr == `STM_OFF_CTRL1) c1Q <= pwdata[7:0];
  end
  always_ff @(posedge ref_clk) begin
    if (rst || wrEn) quietQ <= 2'h0;
    else if (!quiet) quietQ <= quietQ + 2'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_ready; !rst |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_hi; psel && penable && paddr > 12'h01C |-> pslverr; endproperty
  a_err_hi: assert property (p_err_hi) else $error("no error on unmapped");
  property p_err_lo;
    psel && penable && paddr[1:0] == 2'h0 && paddr <= 12'h01C |-> !pslverr;
  endproperty
  a_err_lo: assert property (p_err_lo) else $error("error on mapped");
  property p_tmr; quiet && c1Q.modeSelect == 2'h3 |-> timerOutputEnable; endproperty
  a_tmr: assert property (p_tmr) else $error("pin driven in timer mode");
  property p_force;
    quiet && c1Q.modeSelect == 2'h2 && !c1Q.outputActionSelect[1] |->
      timerOutputPin == ((c1Q.outputActionSelect[0] ~^ c1Q.outputInitialLevel)
      ^ c1Q.outputInvert);
  endproperty
  a_force: assert property (p_force) else $error("forced level wrong");
  property p_p_gap; matchPPulse |=> !matchPPulse; endproperty
  a_p_gap: assert property (p_p_gap) else $error("P match too close");
  property p_hold;
    quiet && !wrEn && c1Q.modeSelect == 2'h0 && c1Q.outputActionSelect == 2'h0
      |=> $stable(timerOutputPin);
  endproperty
  a_hold: assert property (p_hold) else $error("pin moved on no-change");
  property p_no_p;
    quiet && c1Q.modeSelect == 2'h0 && c1Q.clearSourceSelect |-> !matchPPulse;
  endproperty
  a_no_p: assert property (p_no_p) else $error("P flag with A clear");
endmodule // stm_timer_checker
bind stm_timer stm_timer_checker chk_u (.ref_clk(ref_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timerOutputPin(timerOutputPin), .timerOutputEnable(timerOutputEnable),
  .matchAPulse(matchAPulse), .matchPPulse(matchPPulse));
`default_nettype wire

// File: dv/stm_timer_bench.sv
// Self-checking bench of the standard timer
`timescale 1ns/1ps
`default_nettype none
`include "stm_map.svh"
module stm_timer_bench;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pin, pinOeN, aP, pP, lvl, err;
  int mismatches = 0, cmp_count = 0, aCnt = 0, pCnt = 0;
  stm_timer #(.PRESCALE(16'h0001)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerOutputPin(pin), .timerOutputEnable(pinOeN), .matchAPulse(aP),
    .matchPPulse(pP));
  stm_load_model load_u (.timerOutputPin(pin), .timerOutputEnable(pinOeN),
    .loadLevel(lvl));
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    aCnt <= aCnt + int'(aP);
    pCnt <= pCnt + int'(pP);
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic regs_test;
    apb(1'b0, `STM_OFF_CMPP, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `STM_OFF_CMPP, 32'hA5);
    apb(1'b0, `STM_OFF_CMPP, 32'h0);
    chk(rd, 32'hA5);
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic cmp_test;
    int a0;
    int p0;
    apb(1'b1, `STM_OFF_CMPP, 32'h1);
    apb(1'b1, `STM_OFF_CMPAL, 32'h20);
    apb(1'b1, `STM_OFF_CMPAH, 32'h1);
    apb(1'b1, `STM_OFF_CTRL1, 32'h31);
    a0 = aCnt;
    p0 = pCnt;
    apb(1'b1, `STM_OFF_CTRL0, 32'h8);
    repeat (1000) @(posedge ref_clk);
    apb(1'b1, `STM_OFF_CTRL0, 32'h0);
    chk(aCnt - a0, 32'h3);
    chk(pCnt - p0, 32'h0);
    chk(pin, 32'h1);
    apb(1'b0, `STM_OFF_FLAGS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `STM_OFF_FLAGS, 32'h3);
    apb(1'b0, `STM_OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `STM_OFF_CTRL1, 32'h0);
    apb(1'b1, `STM_OFF_CMPAL, 32'h40);
    apb(1'b1, `STM_OFF_CMPAH, 32'h0);
    a0 = aCnt;
    p0 = pCnt;
    apb(1'b1, `STM_OFF_CTRL0, 32'h8);
    repeat (560) @(posedge ref_clk);
    chk(aCnt - a0, 32'h2);
    chk(pCnt - p0, 32'h2);
    apb(1'b1, `STM_OFF_CTRL0, 32'h0);
  endtask
  task automatic pwm_test;
    logic [7:0] c1 [5] = '{8'hA8, 8'hAC, 8'hAA, 8'hA8, 8'h88};
    logic [15:0] av [5] = '{16'h40, 16'h40, 16'h200, 16'h200, 16'h40};
    int win [5] = '{256, 256, 512, 256, 256};
    int hiExp [5] = '{64, 192, 256, 256, 0};
    int p0;
    int hi;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `STM_OFF_CTRL1, {24'h0, c1[i]});
      apb(1'b1, `STM_OFF_CMPAL, {24'h0, av[i][7:0]});
      apb(1'b1, `STM_OFF_CMPAH, {24'h0, av[i][15:8]});
      apb(1'b1, `STM_OFF_CTRL0, 32'h8);
      @(posedge pP);
      hi = 0;
      p0 = pCnt;
      repeat (win[i]) begin
        @(posedge ref_clk);
        hi += int'(lvl);
      end
      chk(hi, hiExp[i]);
      chk(pCnt - p0, 32'h1);
      apb(1'b1, `STM_OFF_CTRL0, 32'h0);
    end
    apb(1'b1, `STM_OFF_CTRL1, 32'hC0);
    repeat (4) @(posedge ref_clk);
    chk(pinOeN, 32'h1);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    regs_test();
    cmp_test();
    pwm_test();
    stop_test();
  end
  // Longest legal run is near 4500 cycles
  initial begin
    #240000;
    mismatches++;
    stop_test();
  end
endmodule // stm_timer_bench
`default_nettype wire
